/* logic/psmc_top.sv */
// power-save mode controller: modes, clock gating, wake and reset exits
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module psmc_top import psmc_pkg::*; #(
  parameter int unsigned NB = 8,
  parameter int unsigned NP = 8
) (
  // clock, reset, enable
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_clk_en,
  // register port
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [31:0]       o_reg_rdata,
  // processor core
  input  wire logic              i_wfi,
  input  wire logic              i_isr_return,
  input  wire logic              i_sleep_on_isr_return,
  input  wire logic              i_deep_sleep_select,
  // module interrupts grouped by clock domain
  input  wire logic              i_irq_bus,
  input  wire logic              i_irq_periph,
  input  wire logic              i_irq_src,
  input  wire logic              i_irq_slow,
  // asynchronous wake sources
  input  wire logic [7:0]        i_ext_irq,
  input  wire logic              i_bod_io_irq,
  input  wire logic              i_bod_core_irq,
  input  wire logic              i_cal_alarm,
  input  wire logic              i_cal_periodic,
  input  wire logic              i_cal_overflow,
  input  wire logic              i_wdt_irq,
  // asynchronous reset sources and supply status
  input  wire logic              i_ext_reset_n,
  input  wire logic              i_bod_io_rst,
  input  wire logic              i_bod_core_rst,
  input  wire logic              i_wdt_rst,
  input  wire logic              i_core_supply_ok,
  input  wire logic              i_scaling_done,
  // clock enables
  output logic                   o_cpu_clk_en,
  output logic      [NB-1:0]     o_bus_clk_en,
  output logic      [NP-1:0]     o_periph_clk_en,
  output logic                   o_gclk_en,
  output logic                   o_main_src_en,
  output logic                   o_sys_rc_en,
  output logic                   o_xtal32_en,
  output logic                   o_rc32_en,
  output logic                   o_slow_clk_sel,
  // power and status
  output logic                   o_core_power_en,
  output logic                   o_core_reset_n,
  output logic                   o_io_hold,
  output logic                   o_retain,
  output logic      [1:0]        o_run_mode,
  output logic      [1:0]        o_scaling,
  output logic      [FEAT_W-1:0] o_feature_en,
  output logic                   o_pm_irq
);

  localparam int unsigned SY_W = WK_W + 6;

  typedef struct packed {
    psmc_fsm_type          fsm;
    psmc_ctrl_type         ctrl;
    logic [NB-1:0]         bus_mask;
    logic [NP-1:0]         per_mask;
    logic [1:0]            saved_run;
    logic [1:0]            slow_snap;
    logic [1:0]            ps_applied;
    logic                  pm_irq;
    logic                  async_wake_enable_reg;
    logic                  wake_exit;
    logic [RC_W-1:0]       reset_cause_reg;
    logic [WK_W-1:0]       bwen;
    logic [WK_W-1:0]       bwcause;
    logic [WK_EXT_W-1:0]   ext_prev;
    logic [31:0]           rdata;
  } psmc_state_type;

  localparam psmc_state_type ST_RST = '{
    fsm: ST_RUN, ctrl: CTRL_RST, bus_mask: BUS_MASK_RST[NB-1:0],
    per_mask: PER_MASK_RST[NP-1:0], saved_run: RUN_ZERO, slow_snap: 2'h0,
    ps_applied: PS_RST, pm_irq: 1'b0, async_wake_enable_reg: 1'b0, wake_exit: 1'b0,
    reset_cause_reg: '0, bwen: '0, bwcause: '0, ext_prev: '0, rdata: 32'h0000_0000};

  psmc_state_type st;
  psmc_state_type next_st;
  psmc_gate_type  gate;
  logic [SY_W-1:0] sy;
  logic [WK_W-1:0] wk_evt;
  logic [WK_W-1:0] wk_bk;
  logic [3:0]      rst_vec;
  logic            rst_any;
  logic            wake_sleep;
  logic            wake_deep;

  if (NB < 1 || NB > 32 || NP < 1 || NP > 32) begin : g_bad_width
    $error("psmc_top mask widths must lie in 1..32");
  end

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers and clock gate decode

  psmc_sync #(.W(SY_W)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_scaling_done, i_core_supply_ok, i_wdt_rst, i_bod_core_rst,
                 i_bod_io_rst, ~i_ext_reset_n, i_wdt_irq, i_cal_overflow,
                 i_cal_periodic, i_cal_alarm, i_bod_core_irq, i_bod_io_irq,
                 i_ext_irq}),
    .o_level   (sy)
  );

  psmc_gate_dec u_gate_dec (
    .i_fsm   (st.fsm),
    .i_level (st.ctrl.level),
    .o_gate  (gate)
  );

  //////////////////////////////////////////////////////////////////////////////
  // wake and reset qualification

  // external lines wake on a level transition only
  assign wk_evt  = {sy[WK_W-1:WK_EXT_W], sy[WK_EXT_W-1:0] ^ st.ext_prev};
  assign wk_bk   = wk_evt & st.bwen;
  assign rst_vec = sy[WK_W+3:WK_W];
  assign rst_any = |rst_vec;

  // deeper levels only hear modules whose clock still runs
  always_comb begin
    wake_sleep = i_irq_slow;
    if (st.ctrl.level < LVL_SRC_STOP) begin
      wake_sleep = wake_sleep | i_irq_src;
    end
    if (st.ctrl.level < LVL_PER_STOP) begin
      wake_sleep = wake_sleep | i_irq_periph;
    end
    if (st.ctrl.level < LVL_BUS_STOP) begin
      wake_sleep = wake_sleep | i_irq_bus;
    end
  end

  assign wake_deep = i_irq_slow | (|wk_bk);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st          = st;
    next_st.rdata    = 32'h0000_0000;
    next_st.ext_prev = sy[WK_EXT_W-1:0];

    if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFS_CTRL:            next_st.rdata = 32'(st.ctrl);
        OFS_BUS_MASK:        next_st.rdata = 32'(st.bus_mask);
        OFS_PERIPH_MASK:     next_st.rdata = 32'(st.per_mask);
        OFS_STATUS:          next_st.rdata = 32'({st.ctrl.run, st.pm_irq, st.ps_applied});
        OFS_RESET_CAUSE:     next_st.rdata = 32'(st.reset_cause_reg);
        OFS_ASYNC_WAKE:      next_st.rdata = 32'(st.async_wake_enable_reg);
        OFS_BKUP_WAKE_EN:    next_st.rdata = 32'(st.bwen);
        OFS_BKUP_WAKE_CAUSE: next_st.rdata = 32'(st.bwcause);
        default:             next_st.rdata = 32'h0000_0000;
      endcase
    end

    if (i_reg_wr) begin
      unique case (i_reg_addr)
        OFS_CTRL:            next_st.ctrl = psmc_ctrl_type'(i_reg_wdata[CTRL_W-1:0]);
        OFS_BUS_MASK:        next_st.bus_mask = i_reg_wdata[NB-1:0];
        OFS_PERIPH_MASK:     next_st.per_mask = i_reg_wdata[NP-1:0];
        OFS_STATUS: begin
          if (i_reg_wdata[STAT_IRQ]) begin
            next_st.pm_irq = 1'b0;
          end
        end
        OFS_RESET_CAUSE:     next_st.reset_cause_reg = st.reset_cause_reg & ~i_reg_wdata[RC_W-1:0];
        OFS_ASYNC_WAKE:      next_st.async_wake_enable_reg = i_reg_wdata[0];
        OFS_BKUP_WAKE_EN:    next_st.bwen = i_reg_wdata[WK_W-1:0];
        OFS_BKUP_WAKE_CAUSE: next_st.bwcause = st.bwcause & ~i_reg_wdata[WK_W-1:0];
        default: begin
        end
      endcase
    end

    unique case (st.fsm)
      ST_RUN: begin
        if (i_wfi || (i_isr_return && i_sleep_on_isr_return)) begin
          next_st.saved_run = st.ctrl.run;
          next_st.slow_snap = {st.ctrl.rc32_en, st.ctrl.xtal_en};
          if (i_wfi && st.ctrl.ps_req) begin
            next_st.fsm = ST_SCALE;
          end else if (i_deep_sleep_select && st.ctrl.bkup_req) begin
            next_st.fsm = ST_BACKUP;
          end else if (st.ctrl.level == LVL_WAIT) begin
            next_st.fsm = ST_WAIT;
          end else if (st.ctrl.level == LVL_RETAIN) begin
            next_st.fsm = ST_RETAIN;
          end else begin
            next_st.fsm = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_sleep) begin
          next_st.fsm      = ST_RUN;
          next_st.ctrl.run = st.saved_run;
        end
      end
      ST_WAIT, ST_RETAIN: begin
        if (wake_deep) begin
          next_st.fsm      = ST_RUN;
          next_st.ctrl.run = st.saved_run;
        end
      end
      ST_BACKUP: begin
        if (|wk_bk) begin
          next_st.fsm       = ST_CORE_RST;
          next_st.wake_exit = 1'b1;
          next_st.bwcause   = next_st.bwcause | wk_bk;
        end
      end
      ST_CORE_RST: begin
        if (sy[WK_W+4]) begin
          next_st.fsm = ST_RUN;
          if (st.wake_exit) begin
            // core registers come back at reset value except the run mode, which returns to the saved one, and ck_sel, xtal_en, rc32_en, which are kept; backup domain kept
            next_st.ctrl         = CTRL_RST;
            next_st.ctrl.ck_sel  = st.ctrl.ck_sel;
            next_st.ctrl.xtal_en = st.ctrl.xtal_en;
            next_st.ctrl.rc32_en = st.ctrl.rc32_en;
            next_st.ctrl.run     = st.saved_run;
            next_st.bus_mask     = BUS_MASK_RST[NB-1:0];
            next_st.per_mask     = PER_MASK_RST[NP-1:0];
            next_st.reset_cause_reg[RC_BKUP] = 1'b1;
            next_st.wake_exit    = 1'b0;
          end
        end
      end
      ST_SCALE: begin
        if (sy[WK_W+5]) begin
          next_st.ps_applied  = st.ctrl.ps;
          next_st.ctrl.ps_req = 1'b0;
          if (st.async_wake_enable_reg) begin
            next_st.pm_irq = 1'b1;
            next_st.fsm    = ST_RUN;
          end else begin
            next_st.fsm = ST_SLEEP;
          end
        end
      end
    endcase

    // a reset source ends any state and lands in run mode zero
    if (rst_any) begin
      next_st.fsm          = ST_CORE_RST;
      next_st.reset_cause_reg       = next_st.reset_cause_reg | {1'b0, rst_vec};
      next_st.wake_exit    = 1'b0;
      next_st.ctrl         = CTRL_RST;
      next_st.ctrl.ck_sel  = st.ctrl.ck_sel;
      next_st.ctrl.xtal_en = st.ctrl.xtal_en;
      next_st.ctrl.rc32_en = st.ctrl.rc32_en;
      next_st.bus_mask     = BUS_MASK_RST[NB-1:0];
      next_st.per_mask     = PER_MASK_RST[NP-1:0];
      next_st.ps_applied   = PS_RST;
      next_st.pm_irq       = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st <= ST_RST;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_reg_rdata     = st.rdata;
  assign o_cpu_clk_en    = gate.cpu;
  assign o_bus_clk_en    = st.bus_mask & {NB{gate.bus}};
  assign o_periph_clk_en = st.per_mask & {NP{gate.periph}};
  assign o_gclk_en       = gate.gclk;
  assign o_main_src_en   = gate.main_src;
  assign o_sys_rc_en     = gate.sys_rc;
  assign o_xtal32_en     = gate.slow & ((st.fsm == ST_RUN) ? st.ctrl.xtal_en : st.slow_snap[0]);
  assign o_rc32_en       = gate.slow & ((st.fsm == ST_RUN) ? st.ctrl.rc32_en : st.slow_snap[1]);
  assign o_slow_clk_sel  = st.ctrl.ck_sel;
  assign o_core_power_en = (st.fsm != ST_BACKUP);
  assign o_core_reset_n  = (st.fsm != ST_BACKUP) && (st.fsm != ST_CORE_RST);
  assign o_io_hold       = (st.fsm != ST_RUN);
  assign o_retain        = (st.fsm == ST_RETAIN);
  assign o_run_mode      = st.ctrl.run;
  assign o_scaling       = st.ps_applied;
  assign o_feature_en    = {FEAT_W{st.ps_applied != PS_ONE}};
  assign o_pm_irq        = st.pm_irq;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n || !i_clk_en);

  chk_reset_run_zero: assert property ($past(!i_reset_n) |->
    (o_run_mode == RUN_ZERO && o_cpu_clk_en && o_periph_clk_en == '0))
    else $error("reset did not start in run mode zero");
  chk_wake_restores: assert property ((st.fsm == ST_SLEEP && !rst_any) ##1
    (st.fsm == ST_RUN) |-> o_run_mode == $past(st.saved_run))
    else $error("wake did not restore run mode");
  chk_reset_exit_zero: assert property (rst_any |=>
    (st.fsm == ST_CORE_RST && o_run_mode == RUN_ZERO && !o_core_reset_n))
    else $error("reset source did not force run mode zero");
  chk_io_hold_save: assert property (!o_cpu_clk_en |-> o_io_hold)
    else $error("io not held while core stopped");
  chk_sleep_gating: assert property ((st.fsm == ST_SLEEP && st.ctrl.level >= LVL_PER_STOP)
    |-> (!o_cpu_clk_en && o_bus_clk_en == '0 && o_periph_clk_en == '0 && o_sys_rc_en))
    else $error("sleep level gating wrong");
  chk_sleep_no_wake: assert property ((st.fsm == ST_SLEEP && st.ctrl.level == LVL_SRC_STOP
    && !i_irq_slow && !rst_any) |=> st.fsm == ST_SLEEP)
    else $error("stopped module woke deep sleep");
  chk_wait_clocks: assert property ((st.fsm == ST_WAIT || st.fsm == ST_RETAIN)
    |-> (!o_main_src_en && !o_gclk_en && !o_cpu_clk_en && o_core_power_en))
    else $error("wait state clocks not stopped");
  chk_backup_power: assert property ((st.fsm == ST_BACKUP && !rst_any && !(|wk_bk))
    |-> (!o_core_power_en && !o_core_reset_n) ##1 (st.fsm == ST_BACKUP && !o_core_power_en))
    else $error("core domain powered in backup");
  chk_scaling_irq: assert property ((st.fsm == ST_SCALE && sy[WK_W+5] && st.async_wake_enable_reg
    && !rst_any) |=> (o_pm_irq && o_scaling == $past(st.ctrl.ps) && st.fsm == ST_RUN))
    else $error("scaling done did not wake core");
  chk_ps_one_feat: assert property ((o_scaling == PS_ONE) |-> o_feature_en == '0)
    else $error("features left on in scaling one");
  chk_backup_wake: assert property ((st.fsm == ST_BACKUP && |wk_bk && !rst_any) |=>
    (st.fsm == ST_CORE_RST && (st.bwcause & $past(wk_bk)) == $past(wk_bk)))
    else $error("backup wake cause not recorded");

  cov_sleep_entry: cover property (st.fsm == ST_RUN ##1 st.fsm == ST_SLEEP);
  cov_backup_wake: cover property (st.fsm == ST_BACKUP ##1 st.fsm == ST_CORE_RST
    ##[1:50] st.fsm == ST_RUN);
  cov_scaling: cover property (st.fsm == ST_SCALE ##1 o_pm_irq);

endmodule : psmc_top

/* logic/psmc_pkg.sv */
// constants and types shared by the power-save mode controller
package psmc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register word offsets
  localparam int unsigned REG_AW          = 4;
  localparam logic [3:0]  OFS_CTRL        = 4'h0;
  localparam logic [3:0]  OFS_BUS_MASK    = 4'h1;
  localparam logic [3:0]  OFS_PERIPH_MASK = 4'h2;
  localparam logic [3:0]  OFS_STATUS      = 4'h3;
  localparam logic [3:0]  OFS_RESET_CAUSE = 4'h4;
  localparam logic [3:0]  OFS_ASYNC_WAKE  = 4'h5;
  localparam logic [3:0]  OFS_BKUP_WAKE_EN = 4'h6;
  localparam logic [3:0]  OFS_BKUP_WAKE_CAUSE = 4'h7;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTRL_W        = 12;
  localparam int unsigned STAT_IRQ      = 2;
  localparam int unsigned RC_W          = 5;
  localparam int unsigned RC_BKUP       = 4;
  localparam int unsigned WK_W          = 14;
  localparam int unsigned WK_EXT_W      = 8;
  localparam int unsigned FEAT_W        = 4;

  //////////////////////////////////////////////////////////////////////////////
  // encodings and reset values
  localparam logic [2:0]  LVL_BUS_STOP  = 3'h1;
  localparam logic [2:0]  LVL_PER_STOP  = 3'h2;
  localparam logic [2:0]  LVL_SRC_STOP  = 3'h3;
  localparam logic [2:0]  LVL_WAIT      = 3'h4;
  localparam logic [2:0]  LVL_RETAIN    = 3'h5;
  localparam logic [1:0]  RUN_ZERO      = 2'h0;
  localparam logic [1:0]  PS_ONE        = 2'h1;
  localparam logic [1:0]  PS_RST        = 2'h0;
  localparam logic [31:0] BUS_MASK_RST  = 32'h0000_0001;
  localparam logic [31:0] PER_MASK_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_WAIT, ST_RETAIN, ST_BACKUP, ST_CORE_RST, ST_SCALE
  } psmc_fsm_type;

  typedef struct packed {
    logic       rc32_en;
    logic       xtal_en;
    logic       ck_sel;
    logic       ps_req;
    logic [1:0] ps;
    logic [1:0] run;
    logic       bkup_req;
    logic [2:0] level;
  } psmc_ctrl_type;

  localparam psmc_ctrl_type CTRL_RST = psmc_ctrl_type'(12'h000);

  typedef struct packed {
    logic cpu;
    logic bus;
    logic periph;
    logic gclk;
    logic main_src;
    logic sys_rc;
    logic slow;
  } psmc_gate_type;

endpackage : psmc_pkg

/* logic/psmc_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module psmc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_clk_en,
  // raw and filtered levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] level;
  } psmc_sync_state_type;

  psmc_sync_state_type st;
  psmc_sync_state_type next_st;

  if (W < 1) begin : g_bad_width
    $error("psmc_sync width must be at least one");
  end

  // a bit moves only once the second and third stages agree
  always_comb begin
    next_st       = st;
    next_st.ff1   = i_async;
    next_st.ff2   = st.ff1;
    next_st.ff3   = st.ff2;
    next_st.level = ((st.ff2 ~^ st.ff3) & st.ff3) | ((st.ff2 ^ st.ff3) & st.level);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

endmodule : psmc_sync

/* logic/psmc_gate_dec.sv */
// decodes mode and sleep level into clock gate enables
`timescale 1ns/1ns
module psmc_gate_dec import psmc_pkg::*; (
  // mode
  input  wire psmc_fsm_type  i_fsm,
  input  wire logic [2:0]    i_level,
  // gates
  output psmc_gate_type      o_gate
);

  always_comb begin
    o_gate = '1;
    unique case (i_fsm)
      ST_RUN: begin
      end
      ST_SLEEP, ST_SCALE: begin
        o_gate.cpu = 1'b0;
        if (i_level >= LVL_BUS_STOP) begin
          o_gate.bus = 1'b0;
        end
        if (i_level >= LVL_PER_STOP) begin
          o_gate.periph = 1'b0;
          o_gate.gclk   = 1'b0;
        end
        if (i_level >= LVL_SRC_STOP) begin
          o_gate.main_src = 1'b0;
        end
      end
      ST_WAIT, ST_RETAIN, ST_BACKUP: begin
        // only the slow oscillators may keep running
        o_gate      = '0;
        o_gate.slow = 1'b1;
      end
      ST_CORE_RST: begin
        o_gate.cpu    = 1'b0;
        o_gate.bus    = 1'b0;
        o_gate.periph = 1'b0;
        o_gate.gclk   = 1'b0;
      end
    endcase
  end

endmodule : psmc_gate_dec

/* testbench/psmc_core_model.sv */
// processor core and core supply model facing the controller
`timescale 1ns/1ns
module psmc_core_model (
  // clock and controller state
  input  wire logic i_sys_clk,
  input  wire logic i_cpu_clk_en,
  input  wire logic i_core_power_en,
  // core requests and supply status
  output logic      o_wfi,
  output logic      o_core_supply_ok,
  output logic      o_scaling_done
);
  logic [3:0] stop_cnt;
  initial begin
    o_wfi = 1'h0;
    o_core_supply_ok = 1'h1;
    o_scaling_done = 1'h0;
    stop_cnt = 4'h0;
  end
  // the regulator settles nine cycles after the core stops
  always @(posedge i_sys_clk) begin
    stop_cnt <= i_cpu_clk_en ? 4'h0 : stop_cnt + {3'h0, stop_cnt != 4'hf};
    o_scaling_done <= (stop_cnt > 4'h7) && i_core_power_en;
    o_core_supply_ok <= i_core_power_en;
  end
  task automatic exec_wfi();
    @(posedge i_sys_clk);
    o_wfi <= 1'h1;
    @(posedge i_sys_clk);
    o_wfi <= 1'h0;
  endtask : exec_wfi
endmodule : psmc_core_model

/* testbench/psmc_tb_top.sv */
// self-checking bench for the power-save mode controller
`timescale 1ns/1ns
module psmc_tb_top import psmc_pkg::*;;
  logic        i_sys_clk = 1'h0, i_reset_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
  logic        i_deep_sleep_select = 1'h0, i_irq_bus = 1'h0, i_irq_slow = 1'h0;
  logic        i_irq_periph = 1'h0, i_wdt_rst = 1'h0, i_wfi, i_core_supply_ok, i_scaling_done;
  logic        i_clk_en = 1'h1, i_isr_return = 1'h0, i_sleep_on_isr_return = 1'h0;
  logic        i_irq_src = 1'h0, i_wdt_irq = 1'h0, i_ext_reset_n = 1'h1;
  logic        i_bod_io_rst = 1'h0, i_bod_core_rst = 1'h0;
  logic        o_sys_rc_en, o_rc32_en, o_slow_clk_sel;
  logic [7:0]  i_ext_irq = 8'h0, o_bus_clk_en, o_periph_clk_en;
  logic [1:0]  o_run_mode, o_scaling;
  logic [3:0]  o_feature_en;
  logic        o_cpu_clk_en, o_gclk_en, o_main_src_en, o_xtal32_en, o_core_power_en;
  logic        o_core_reset_n, o_io_hold, o_retain, o_pm_irq;
  int          err_total = 0, checked = 0, cyc = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  psmc_top u_psmc_top (
    .i_sys_clk, .i_reset_n, .i_clk_en, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_wfi, .i_isr_return, .i_sleep_on_isr_return,
    .i_deep_sleep_select, .i_irq_bus, .i_irq_periph, .i_irq_src, .i_irq_slow,
    .i_ext_irq, .i_bod_io_irq(1'h0), .i_bod_core_irq(1'h0), .i_cal_alarm(1'h0),
    .i_cal_periodic(1'h0), .i_cal_overflow(1'h0), .i_wdt_irq, .i_ext_reset_n,
    .i_bod_io_rst, .i_bod_core_rst, .i_wdt_rst, .i_core_supply_ok,
    .i_scaling_done, .o_cpu_clk_en, .o_bus_clk_en, .o_periph_clk_en, .o_gclk_en,
    .o_main_src_en, .o_sys_rc_en, .o_xtal32_en, .o_rc32_en, .o_slow_clk_sel,
    .o_core_power_en, .o_core_reset_n, .o_io_hold, .o_retain, .o_run_mode, .o_scaling,
    .o_feature_en, .o_pm_irq
  );
  psmc_core_model u_psmc_core_model (
    .i_sys_clk, .i_cpu_clk_en(o_cpu_clk_en), .i_core_power_en(o_core_power_en),
    .o_wfi(i_wfi), .o_core_supply_ok(i_core_supply_ok), .o_scaling_done(i_scaling_done)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'h1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'h1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'h0;
    @(negedge i_sys_clk);
    d = o_reg_rdata;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      close_out();
    end
  end
  initial begin : main
    logic [31:0] d;
    repeat (10) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    repeat (5) @(negedge i_sys_clk);
    chk({o_run_mode, o_cpu_clk_en, o_io_hold, o_core_power_en}, 5'h5);
    wr(OFS_BUS_MASK, 32'hff);
    wr(OFS_PERIPH_MASK, 32'hff);
    // levels 0-3 sleep, 4 wait, 5 retention; bus irq only wakes level 0
    for (int lv = 0; lv < 6; lv++) begin
      wr(OFS_CTRL, 32'h620 | lv);
      u_psmc_core_model.exec_wfi();
      i_irq_bus <= 1'h1;
      repeat (6) @(negedge i_sys_clk);
      chk({o_cpu_clk_en, |o_bus_clk_en, |o_periph_clk_en, o_gclk_en, o_main_src_en,
           o_sys_rc_en, o_io_hold, o_xtal32_en, o_rc32_en, o_slow_clk_sel, o_retain},
          {lv == 0, lv < 1, lv < 2, lv < 2, lv < 3, lv < 4, lv != 0, 3'h5, lv == 5});
      @(posedge i_sys_clk);
      i_irq_slow <= 1'h1;
      wait (o_cpu_clk_en);
      @(negedge i_sys_clk);
      chk({o_run_mode, o_io_hold, o_bus_clk_en}, 11'h4ff);
      @(posedge i_sys_clk);
      i_irq_bus <= 1'h0;
      i_irq_slow <= 1'h0;
    end
    // sleep on handler return at level 2: peripheral irq must not wake, frozen state holds
    wr(OFS_CTRL, 32'h622);
    i_sleep_on_isr_return <= 1'h1;
    i_isr_return <= 1'h1;
    @(posedge i_sys_clk);
    i_isr_return <= 1'h0;
    i_irq_periph <= 1'h1;
    repeat (4) @(negedge i_sys_clk);
    chk({o_cpu_clk_en, o_io_hold}, 2'h1);
    @(posedge i_sys_clk);
    i_irq_src <= 1'h1;
    i_clk_en <= 1'h0;
    repeat (4) @(negedge i_sys_clk);
    chk(o_cpu_clk_en, 1'h0);
    @(posedge i_sys_clk);
    i_clk_en <= 1'h1;
    wait (o_cpu_clk_en);
    @(negedge i_sys_clk);
    chk(o_run_mode, 2'h2);
    @(posedge i_sys_clk);
    i_irq_periph <= 1'h0;
    i_irq_src <= 1'h0;
    i_sleep_on_isr_return <= 1'h0;
    wr(OFS_CTRL, 32'h21);
    u_psmc_core_model.exec_wfi();
    i_wdt_rst <= 1'h1;
    wait (!o_core_reset_n);
    @(posedge i_sys_clk);
    i_wdt_rst <= 1'h0;
    wait (o_core_reset_n);
    @(negedge i_sys_clk);
    chk(o_run_mode, 2'h0);
    rd(OFS_RESET_CAUSE, d);
    chk(d[3], 1'h1);
    wr(OFS_BKUP_WAKE_EN, 32'h2001);
    wr(OFS_CTRL, 32'h18);
    i_deep_sleep_select <= 1'h1;
    u_psmc_core_model.exec_wfi();
    repeat (2) @(negedge i_sys_clk);
    chk({o_core_power_en, o_io_hold}, 2'h1);
    @(posedge i_sys_clk);
    i_ext_irq <= 8'h1;
    i_wdt_irq <= 1'h1;
    wait (o_core_power_en);
    wait (o_core_reset_n);
    @(negedge i_sys_clk);
    chk(o_run_mode, 2'h1);
    rd(OFS_RESET_CAUSE, d);
    chk(d[4], 1'h1);
    rd(OFS_BKUP_WAKE_CAUSE, d);
    chk(d[13:0], 14'h2001);
    @(posedge i_sys_clk);
    i_deep_sleep_select <= 1'h0;
    i_wdt_irq <= 1'h0;
    wr(OFS_ASYNC_WAKE, 32'h1);
    wr(OFS_CTRL, 32'h140);
    u_psmc_core_model.exec_wfi();
    wait (o_pm_irq);
    @(negedge i_sys_clk);
    chk({o_scaling, o_feature_en, o_cpu_clk_en}, 7'h21);
    // reset sources end backup and always land in run mode zero
    wr(OFS_CTRL, 32'h38);
    i_deep_sleep_select <= 1'h1;
    u_psmc_core_model.exec_wfi();
    repeat (2) @(negedge i_sys_clk);
    chk(o_core_power_en, 1'h0);
    @(posedge i_sys_clk);
    i_ext_reset_n <= 1'h0;
    i_bod_io_rst <= 1'h1;
    i_bod_core_rst <= 1'h1;
    wait (o_core_power_en);
    @(posedge i_sys_clk);
    i_ext_reset_n <= 1'h1;
    i_bod_io_rst <= 1'h0;
    i_bod_core_rst <= 1'h0;
    wait (o_core_reset_n);
    @(negedge i_sys_clk);
    chk(o_run_mode, 2'h0);
    rd(OFS_RESET_CAUSE, d);
    chk(d[2:0], 3'h7);
    close_out();
  end
endmodule : psmc_tb_top
